// file: common/late_write_pkg.sv
// constants, carriers and helpers for the late-write synchronous ram core
//
// Overview of operation
// (R01) All control inputs except output enable are sampled on the rising clock edge.
// (R02) A read's data appears in the output latch after the same cycle's falling edge; the core loads dqOut at the next rising edge instead.
// (R03) The output latch closes on the next rising edge and holds the read data.
// (R04) A new read address is taken while prior read data is presented; reads stream.
// (R05) Write may follow read and read may follow write with no idle cycle.
// (R06) Chip select sampled high turns output drivers off within that cycle; the core clears drive at the next rising edge instead.
// (R07) Write sampled low turns output drivers off within that cycle; the core clears drive at the next rising edge instead.
// (R08) Select low and write high turn drivers on only after the falling edge.
// (R09) Output enable gates the output drivers with no clock edge involved.
// (R10) Each byte-write enable governs one nine-bit lane, timed like the write input.
// (R11) Byte-write enables are ignored on reads; reads return all lanes.
// (R12) A write updates exactly the lanes whose enables are active.
// (R13) A cycle that writes any lane performs no read at that address.
// (R14) A write with no lane enabled changes nothing but still turns drivers off.
// (R15) Write address is taken at one edge, write data at the following edge.
// (R16) A pending write sits in a one-entry buffer and is committed later, unseen.
// (R17) Reads matching the buffered address get buffered data, full or partial writes.
// (R18) The controller keeps the clock running 1.0 us before normal cycles.
// (R19) Partial-write hits merge buffered enabled lanes with array data for the rest.
package late_write_pkg;

  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int ADDR_W = 17;
  localparam int LANES  = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;

  // ----------------------------------------
  // power-up dwell, kept by the controller
  // ----------------------------------------
  localparam int MCLK_NS   = 40;
  localparam int DWELL_NS  = 1000;
  localparam int DWELL_CYC = (DWELL_NS + MCLK_NS - 1) / MCLK_NS;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic              chipSel_n;
    logic              sync_write_n;
    logic [LANES-1:0]  byte_write_n;
    logic [ADDR_W-1:0] address_in;
  } mem_req_s;

  typedef struct packed {
    logic              stageValid;
    logic [ADDR_W-1:0] stageAddr;
    logic [LANES-1:0]  stageMask;
    logic              bufValid;
    logic [ADDR_W-1:0] bufAddr;
    logic [LANES-1:0]  bufMask;
    logic [DATA_W-1:0] bufData;
    logic              rdPend;
    logic [ADDR_W-1:0] rdAddr;
    logic [DATA_W-1:0] dqOut;
    logic              drive;
  } core_state_s;

  // ----------------------------------------
  // lane mask to bit mask
  // ----------------------------------------
  function automatic logic [DATA_W-1:0] laneExpand(input logic [LANES-1:0] mask);
    logic [DATA_W-1:0] bits;
    bits = '0;
    for (int l = 0; l < LANES; l++)
    begin
      bits[l*LANE_W +: LANE_W] = {LANE_W{mask[l]}};
    end
    return bits;
  endfunction : laneExpand

endpackage : late_write_pkg

// file: hdl/lw_sram_array.sv
// storage array with one lane-masked write port and one asynchronous read port
`timescale 1ns/1ps
`default_nettype none

module lw_sram_array #(
  parameter int AW     = late_write_pkg::ADDR_W,
  parameter int LANES  = late_write_pkg::LANES,
  parameter int LANE_W = late_write_pkg::LANE_W
) (
  // clock
  input  wire logic                    mclk,
  // write port
  input  wire logic                    wrEn,
  input  wire logic [AW-1:0]           wrAddr,
  input  wire logic [LANES-1:0]        wrMask,
  input  wire logic [LANES*LANE_W-1:0] wrData,
  // read port
  input  wire logic [AW-1:0]           rdAddr,
  output logic      [LANES*LANE_W-1:0] rdData
);

  localparam int DEPTH = 1 << AW;

  // ----------------------------------------
  // one storage column per lane
  // ----------------------------------------
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    logic [LANE_W-1:0] laneMem [DEPTH];

    always_ff @(posedge mclk)
    begin
      if (wrEn && wrMask[l])
      begin
        laneMem[wrAddr] <= wrData[l*LANE_W +: LANE_W]; // R12
      end
    end

    assign rdData[l*LANE_W +: LANE_W] = laneMem[rdAddr];
  end

endmodule : lw_sram_array
`default_nettype wire

// file: hdl/late_write_sram.sv
// late-write synchronous ram core: capture, write buffer, bypass and output drive
`timescale 1ns/1ps
`default_nettype none

module late_write_sram (
  // clock and reset
  input  wire logic                              mclk,
  input  wire logic                              reset,
  // memory bus control
  input  wire late_write_pkg::mem_req_s          req,
  input  wire logic                              outEnable_n,
  // data bus
  input  wire logic [late_write_pkg::DATA_W-1:0] dataIn,
  output logic      [late_write_pkg::DATA_W-1:0] dqOut,
  output logic                                   dqOe
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  late_write_pkg::core_state_s st_r;
  late_write_pkg::core_state_s st_nxt;

  logic                              isSel;
  logic                              isWr;
  logic                              isRd;
  logic [late_write_pkg::LANES-1:0]  wrMask;
  logic                              bufHit;
  logic [late_write_pkg::DATA_W-1:0] hitBits;
  logic                              commit;
  logic [late_write_pkg::DATA_W-1:0] arrData;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  always_comb
  begin
    isSel  = ~req.chipSel_n;                 // R01
    isWr   = isSel & ~req.sync_write_n;      // R01
    isRd   = isSel & req.sync_write_n;       // R11
    wrMask = ~req.byte_write_n;              // R10
    bufHit = st_r.bufValid && (st_r.bufAddr == st_r.rdAddr);
    hitBits = bufHit ? late_write_pkg::laneExpand(st_r.bufMask) : '0;
    commit = st_r.stageValid & st_r.bufValid;
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  lw_sram_array #(
    .AW     (late_write_pkg::ADDR_W),
    .LANES  (late_write_pkg::LANES),
    .LANE_W (late_write_pkg::LANE_W)
  ) u_array (
    .mclk   (mclk),
    .wrEn   (commit),
    .wrAddr (st_r.bufAddr),
    .wrMask (st_r.bufMask),
    .wrData (st_r.bufData),
    .rdAddr (st_r.rdAddr),
    .rdData (arrData)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    // write address phase: stage only when some lane is enabled
    st_nxt.stageValid = isWr & (|wrMask);     // R14
    st_nxt.stageAddr  = req.address_in;       // R15
    st_nxt.stageMask  = wrMask;               // R12
    // write data phase: data one edge after address
    if (st_r.stageValid)
    begin
      st_nxt.bufValid = 1'b1;                 // R16
      st_nxt.bufAddr  = st_r.stageAddr;       // R16
      st_nxt.bufMask  = st_r.stageMask;       // R16
      st_nxt.bufData  = dataIn;               // R15
    end
    // read address phase, never on a write cycle
    st_nxt.rdPend = isRd;                     // R13
    st_nxt.rdAddr = req.address_in;           // R04
    // output latch opens for a pending read, otherwise holds
    if (st_r.rdPend)
    begin
      st_nxt.dqOut = (arrData & ~hitBits) | (st_r.bufData & hitBits); // R17
    end
    // drivers follow the command of the cycle being presented
    st_nxt.drive = st_r.rdPend;               // R06
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign dqOut = st_r.dqOut;
  assign dqOe  = st_r.drive & ~outEnable_n;   // R09

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_read;
    isRd;
  endsequence

  sequence s_write;
    isWr;
  endsequence

  sequence s_lane_write;
    isWr && (|wrMask);
  endsequence

  property p_read_drive;
    s_read |=> st_r.drive == 1'b0 || st_r.rdPend ##1 st_r.drive;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read did not enable drivers"); // R08

  property p_write_off;
    s_write |=> ##1 !st_r.drive;
  endproperty
  a_write_off: assert property (p_write_off) else $error("write cycle drove the bus"); // R07

  property p_desel_off;
    !isSel |=> ##1 !st_r.drive;
  endproperty
  a_desel_off: assert property (p_desel_off) else $error("deselected cycle drove the bus"); // R06

  property p_latch_hold;
    !st_r.rdPend |=> $stable(st_r.dqOut);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("output latch changed without a read"); // R03

  property p_stream;
    s_read ##1 s_read |=> st_r.drive [*2];
  endproperty
  a_stream: assert property (p_stream) else $error("back-to-back reads lost drive"); // R04

  property p_turnaround;
    s_read ##1 s_write ##1 s_read |-> st_r.drive ##1 !st_r.drive ##1 st_r.drive;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("read-write-read turnaround wrong"); // R05

  property p_oe_gate;
    outEnable_n |-> !dqOe;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("output enable did not gate drivers"); // R09

  property p_nop_write;
    isWr && !(|wrMask) |=> !st_r.stageValid ##1 $stable(st_r.bufData);
  endproperty
  a_nop_write: assert property (p_nop_write) else $error("empty write changed state"); // R14

  property p_late_data;
    s_lane_write |=> st_r.stageValid ##1 (st_r.bufValid && st_r.bufData == $past(dataIn)
      && st_r.bufMask == $past(st_r.stageMask));
  endproperty
  a_late_data: assert property (p_late_data) else $error("write data not taken one edge late"); // R15

  property p_mask_taken;
    s_lane_write |=> st_r.stageMask == ~$past(req.byte_write_n);
  endproperty
  a_mask_taken: assert property (p_mask_taken) else $error("lane mask not taken with write"); // R10

  property p_read_no_stage;
    s_read |=> !st_r.stageValid && st_r.rdPend;
  endproperty
  a_read_no_stage: assert property (p_read_no_stage) else $error("read staged a write"); // R11

  property p_write_no_read;
    s_write |=> !st_r.rdPend;
  endproperty
  a_write_no_read: assert property (p_write_no_read) else $error("write cycle also read"); // R13

  property p_commit_once;
    commit |=> st_r.bufAddr == $past(st_r.stageAddr);
  endproperty
  a_commit_once: assert property (p_commit_once) else $error("buffer not refilled on commit"); // R16

  property p_bypass;
    st_r.rdPend && bufHit |=> (st_r.dqOut & $past(hitBits)) == ($past(st_r.bufData) & $past(hitBits));
  endproperty
  a_bypass: assert property (p_bypass) else $error("buffered lanes not forwarded"); // R17

  property p_merge;
    st_r.rdPend |=> (st_r.dqOut & ~$past(hitBits)) == ($past(arrData) & ~$past(hitBits));
  endproperty
  a_merge: assert property (p_merge) else $error("array lanes wrong on read"); // R19

  property p_launch;
    st_r.rdPend |=> st_r.drive;
  endproperty
  a_launch: assert property (p_launch) else $error("latched read not driven"); // R02

  // ----------------------------------------
  // further checks
  // ----------------------------------------
  property p_reset_quiet;
    @(posedge mclk) disable iff (1'b0)
    reset |=> !st_r.drive && (st_r.dqOut == '0) && !st_r.bufValid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset left state active"); // R03

  property p_desel_no_pend;
    !isSel |=> !st_r.rdPend && !st_r.stageValid;
  endproperty
  a_desel_no_pend: assert property (p_desel_no_pend) else $error("deselected cycle took a command"); // R06

  property p_wr_addr;
    s_lane_write |=> st_r.stageAddr == $past(req.address_in);
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address not taken"); // R15

  property p_buf_hold;
    !st_r.stageValid |=> $stable(st_r.bufData) && $stable(st_r.bufAddr);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("write buffer changed without a write"); // R16

  property p_rd_addr;
    s_read |=> st_r.rdAddr == $past(req.address_in);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address not taken"); // R04

  property p_wr_then_rd;
    s_write ##1 s_read |=> !st_r.drive ##1 st_r.drive;
  endproperty
  a_wr_then_rd: assert property (p_wr_then_rd) else $error("write-read turnaround wrong"); // R05

  property p_oe_follow;
    !outEnable_n && st_r.drive |-> dqOe;
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("enabled drivers stayed off"); // R09

  property p_nop_no_commit;
    isWr && !(|wrMask) |=> !commit;
  endproperty
  a_nop_no_commit: assert property (p_nop_no_commit) else $error("empty write committed the buffer"); // R14

  property p_rd_order;
    s_read |=> st_r.rdPend ##1 st_r.drive;
  endproperty
  a_rd_order: assert property (p_rd_order) else $error("read not presented one cycle later"); // R02

endmodule : late_write_sram
`default_nettype wire

// file: sim/lw_ctrl_model.sv
// controller model: issues bus commands and late write data
`timescale 1ns/1ps
`default_nettype none

module lw_ctrl_model (
  // clock
  input  wire logic                             mclk,
  // memory bus
  output var  late_write_pkg::mem_req_s         req,
  output var  logic [late_write_pkg::DATA_W-1:0] dataIn
);
  logic [late_write_pkg::DATA_W:0] wrDat;

  initial
  begin
    req    = '{1'b1, 1'b1, 4'hf, 17'h00000};
    dataIn = '0;
    wrDat  = '0;
  end

  // data follows the write address by one edge; otherwise the bus toggles
  always @(posedge mclk)
  begin
    dataIn <= wrDat[late_write_pkg::DATA_W] ? wrDat[late_write_pkg::DATA_W-1:0] : ~dataIn;
  end

  // one command per rising edge, held until the next edge
  task automatic cmd(input logic csN, input logic wrN, input logic [3:0] m, input logic [16:0] a,
                     input logic [late_write_pkg::DATA_W-1:0] d);
    @(posedge mclk);
    req   <= '{csN, wrN, m, a};
    wrDat <= {~csN & ~wrN, d};
  endtask : cmd

  // clock keeps running before any normal cycle
  task automatic dwell();
    repeat (late_write_pkg::DWELL_CYC) @(posedge mclk);
  endtask : dwell
endmodule : lw_ctrl_model

`default_nettype wire

// file: sim/late_write_sram_bench.sv
// self-checking bench for the late-write ram core
`timescale 1ns/1ps
`default_nettype none

module late_write_sram_bench;
  localparam logic [35:0] D1 = 36'h123456789;
  localparam logic [35:0] D2 = 36'h0aaaaa1ff;
  localparam logic [35:0] D3 = 36'h9abcdef01;
  localparam logic [35:0] MG = {D1[35:9], D2[8:0]};
  logic                              mclk;
  logic                              reset;
  logic                              outEnable_n;
  logic                              dqOe;
  late_write_pkg::mem_req_s          req;
  logic [late_write_pkg::DATA_W-1:0] dataIn;
  logic [late_write_pkg::DATA_W-1:0] dqOut;
  int                                nErrors = 0;
  int                                checked = 0;
  int                                cycles = 0;

  late_write_sram i_late_write_sram (.mclk(mclk), .reset(reset), .req(req), .outEnable_n(outEnable_n),
                                     .dataIn(dataIn), .dqOut(dqOut), .dqOe(dqOe));
  lw_ctrl_model i_lw_ctrl_model (.mclk(mclk), .req(req), .dataIn(dataIn));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic chk_data(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp)
    begin
      nErrors++;
      $display("MISMATCH %0t data %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      nErrors++;
      $display("MISMATCH %0t drive %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic complete_run();
    if (nErrors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      nErrors++;
      complete_run();
    end
  end

  // ----------------------------------------
  // bus helpers
  // ----------------------------------------
  task automatic rd(input logic [16:0] a, input logic [3:0] m);
    i_lw_ctrl_model.cmd(1'b0, 1'b1, m, a, '0);
  endtask : rd

  task automatic wr(input logic [16:0] a, input logic [3:0] m, input logic [35:0] d);
    i_lw_ctrl_model.cmd(1'b0, 1'b0, m, a, d);
  endtask : wr

  task automatic idle();
    i_lw_ctrl_model.cmd(1'b1, 1'b1, 4'hf, 17'h00000, '0);
  endtask : idle

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_bypass();
    wr(17'h00010, 4'h0, D1);
    rd(17'h00010, 4'hf);
    idle();
    @(negedge mclk);
    chk_bit(dqOe, 1'b0);
    idle();
    @(negedge mclk);
    chk_data(dqOut, D1);
    chk_bit(dqOe, 1'b1);
  endtask : t_bypass

  task automatic t_merge();
    wr(17'h00010, 4'he, D2);
    rd(17'h00010, 4'h0);
    idle();
    @(negedge mclk);
    chk_bit(dqOe, 1'b0);
    idle();
    @(negedge mclk);
    chk_data(dqOut, MG);
  endtask : t_merge

  task automatic t_nolane();
    wr(17'h00010, 4'hf, D3);
    rd(17'h00010, 4'hf);
    idle();
    @(negedge mclk);
    chk_bit(dqOe, 1'b0);
    idle();
    @(negedge mclk);
    chk_data(dqOut, MG);
  endtask : t_nolane

  task automatic t_stream();
    wr(17'h1ffff, 4'h0, D3);
    rd(17'h00010, 4'h5);
    rd(17'h1ffff, 4'h0);
    @(negedge mclk);
    chk_bit(dqOe, 1'b0);
    idle();
    @(negedge mclk);
    chk_data(dqOut, MG);
    idle();
    @(negedge mclk);
    chk_data(dqOut, D3);
    chk_bit(dqOe, 1'b1);
    idle();
    @(negedge mclk);
    chk_bit(dqOe, 1'b0);
    chk_data(dqOut, D3);
  endtask : t_stream

  task automatic t_oe();
    rd(17'h1ffff, 4'hf);
    idle();
    idle();
    @(negedge mclk);
    chk_bit(dqOe, 1'b1);
    outEnable_n <= 1'b1;
    #2;
    chk_bit(dqOe, 1'b0);
    outEnable_n <= 1'b0;
    #2;
    chk_bit(dqOe, 1'b1);
    chk_data(dqOut, D3);
  endtask : t_oe

  initial
  begin
    reset       = 1'b1;
    outEnable_n = 1'b0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    i_lw_ctrl_model.dwell();
    t_bypass();
    t_merge();
    t_nolane();
    t_stream();
    t_oe();
    complete_run();
  end
endmodule : late_write_sram_bench

`default_nettype wire
